// >>> pkg/probe_latch_pkg.sv
/*
  Constants for the two-channel probe position latch.
  Assumes a 20 MHz clock and byte-addressed Avalon-MM register access.
*/
package probe_latch_pkg;
  // Register indices, byte address is four times the index
  localparam logic [15:0] IDX_P1_RISE  = 16'h60BA;
  localparam logic [15:0] IDX_P1_FALL  = 16'h60BB;
  localparam logic [15:0] IDX_P2_RISE  = 16'h60BC;
  localparam logic [15:0] IDX_P2_FALL  = 16'h60BD;
  localparam logic [15:0] IDX_CONTROL  = 16'h60B8;
  localparam logic [15:0] IDX_STATUS   = 16'h60B9;
  localparam logic [15:0] IDX_CONFIG   = 16'h6100;
  localparam logic [15:0] IDX_FILTER   = 16'h6101;
  localparam logic [15:0] IDX_RESTART  = 16'h6102;

  // Control word field positions, per-channel base offset
  localparam int CH2_BASE      = 8;
  localparam int CTL_ENABLE    = 0;
  localparam int CTL_CONT      = 1;
  localparam int CTL_INDEX_SRC = 2;
  localparam int CTL_RISE_EN   = 4;
  localparam int CTL_FALL_EN   = 5;
  // Status word field positions
  localparam int ST_ENABLED    = 0;
  localparam int ST_RISE_DONE  = 1;
  localparam int ST_FALL_DONE  = 2;
  localparam int ST_COUNT_LO   = 6;

  // Config register fields
  localparam int CFG_ROUTE1    = 0;
  localparam int CFG_ROUTE2    = 2;
  localparam int CFG_POL1      = 4;
  localparam int CFG_POL2      = 5;

  // Routing codes
  localparam logic [1:0] ROUTE_CH1  = 2'h0;
  localparam logic [1:0] ROUTE_CH2  = 2'h1;
  localparam logic [1:0] ROUTE_NONE = 2'h2;

  // Reset values
  localparam logic [5:0]  CONFIG_RESET = 6'h04;  // Input 1 to ch1, input 2 to ch2, both uninverted
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [9:0]  FILTER_RESET  = 10'h000;
  localparam logic [9:0]  FILTER_MAX    = 10'h3E8;

  // Filter time unit and clock
  localparam int FILTER_UNIT_NS = 10;
  localparam int CLK_PERIOD_NS  = 50;
endpackage

// >>> verilog/probe_input_filter.sv
/*
  Polarity and glitch filter for one probe input.
  Assumes the input is synchronous to mclk; filter time counted in 10 ns units.
*/
`timescale 1ns/1ns
module probe_input_filter #(
  parameter int FILTER_W = 10
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Configuration
  input  wire logic                invert,
  input  wire logic [FILTER_W-1:0] filterTime,
  // Pin and result
  input  wire logic                pin,
  output logic                     level
);
  typedef struct packed {
    logic                lvl;
    logic [FILTER_W+2:0] cnt;
  } state_type;

  state_type           cur;
  state_type           next_cur;
  logic                active;
  logic [FILTER_W+3:0] holdNs;
  logic [FILTER_W+2:0] target;

  // Width must hold the largest filter setting
  if (FILTER_W < 10) begin : g_bad_width
    $error("FILTER_W too small for the filter range");
  end

  // Uninverted pin is active low
  assign active = invert ? pin : ~pin;
  // Product needs one bit more than the count, or long times wrap short
  assign holdNs = (FILTER_W+4)'(filterTime) * (FILTER_W+4)'(probe_latch_pkg::FILTER_UNIT_NS)
                  + (FILTER_W+4)'(probe_latch_pkg::CLK_PERIOD_NS - 1);
  // Round the hold time up to whole clock cycles
  assign target = (FILTER_W+3)'(holdNs / (FILTER_W+4)'(probe_latch_pkg::CLK_PERIOD_NS));

  // Level must hold its new value for the filter time
  always_comb begin
    next_cur = cur;
    if (active == cur.lvl) begin
      next_cur.cnt = '0;
    end else if (target == '0 || cur.cnt + 1'b1 >= target) begin
      next_cur.lvl = active;
      next_cur.cnt = '0;
    end else begin
      next_cur.cnt = cur.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign level = cur.lvl;
endmodule

// >>> verilog/probe_channel.sv
/*
  One probe channel: edge detection, single/continuous trigger and latching.
  Assumes filtered trigger levels and the position arrive on mclk.
*/
`timescale 1ns/1ns
module probe_channel (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Control bits of this channel
  input  wire logic [5:0]  ctl,
  // Triggers
  input  wire logic        extLevel,
  input  wire logic        indexLevel,
  input  wire logic [31:0] position,
  // Results
  output logic [31:0]      risePos,
  output logic [31:0]      fallPos,
  output logic [7:0]       status
);
  typedef struct packed {
    logic        prevLvl;
    logic        prevEn;
    logic        riseDone;
    logic        fallDone;
    logic [1:0]  count;
    logic [31:0] rise;
    logic [31:0] fall;
  } state_type;

  state_type cur;
  state_type next_cur;
  logic lvl;
  logic en;
  logic rising;
  logic falling;
  logic takeRise;
  logic takeFall;

  assign en  = ctl[probe_latch_pkg::CTL_ENABLE];
  assign lvl = ctl[probe_latch_pkg::CTL_INDEX_SRC] ? indexLevel : extLevel;
  assign rising  = lvl & ~cur.prevLvl;
  assign falling = ~lvl & cur.prevLvl;
  // Single mode takes only the first valid rising and the first valid falling edge after enabling
  assign takeRise = en & rising & ctl[probe_latch_pkg::CTL_RISE_EN]
                    & (ctl[probe_latch_pkg::CTL_CONT] | ~cur.riseDone);
  assign takeFall = en & falling & ctl[probe_latch_pkg::CTL_FALL_EN]
                    & (ctl[probe_latch_pkg::CTL_CONT] | ~cur.fallDone);

  // Latching, done flags cleared on a fresh enable
  always_comb begin
    next_cur = cur;
    next_cur.prevLvl = lvl;
    next_cur.prevEn  = en;
    if (en && !cur.prevEn) begin
      next_cur.riseDone = 1'b0;
      next_cur.fallDone = 1'b0;
      next_cur.count    = 2'h0;
    end
    if (takeRise) begin
      next_cur.rise     = position;
      next_cur.riseDone = 1'b1;
    end
    if (takeFall) begin
      next_cur.fall     = position;
      next_cur.fallDone = 1'b1;
    end
    if ((takeRise || takeFall) && ctl[probe_latch_pkg::CTL_CONT]) begin
      next_cur.count = cur.count + 2'h1; // wraps 3 to 0
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign risePos = cur.rise;
  assign fallPos = cur.fall;
  // Status byte of this channel
  always_comb begin
    status = 8'h00;
    status[probe_latch_pkg::ST_ENABLED]   = en;
    status[probe_latch_pkg::ST_RISE_DONE] = cur.riseDone;
    status[probe_latch_pkg::ST_FALL_DONE] = cur.fallDone;
    status[probe_latch_pkg::ST_COUNT_LO +: 2] = cur.count;
  end
endmodule

// >>> verilog/touch_probe_position_latch.sv
/*
  Two-channel probe position latch with Avalon-MM register slave.
  Assumes inputs synchronous to mclk and a master that holds requests
  until waitrequest is low.
*/
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// How it works
// - channel 1 rising edge latches position
// - channel 1 falling edge latches position
// - channel 2 rising edge latches position
// - channel 2 falling edge latches position
// - first input routing 0..2, after restart
// - second input routing 0..2, default 1
// - filter time 0..1000 x10ns, immediate
// - first input polarity, after restart
// - second input polarity, after restart
// - control word per-channel enable/mode/source/edges
// - single mode latches once, continuous always
// - status word shows enabled and done
// - continuous latch counter wraps 3 to 0
module touch_probe_position_latch (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [17:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Probe pins and position feedback
  input  wire logic        first_probe_input,
  input  wire logic        second_probe_input,
  input  wire logic        indexPulse,
  input  wire logic [31:0] position
);
  typedef struct packed {
    logic [15:0] control;
    logic [9:0]  filter;
    logic [5:0]  configPending;
    logic [5:0]  configActive;
    logic [31:0] rdata;
    logic        ack;
  } state_type;

  state_type cur;
  state_type next_cur;
  logic [15:0] index;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic        lvl1;
  logic        lvl2;
  logic        ext1;
  logic        ext2;
  logic [31:0] pos1Rise;
  logic [31:0] pos1Fall;
  logic [31:0] pos2Rise;
  logic [31:0] pos2Fall;
  logic [7:0]  stat1;
  logic [7:0]  stat2;
  logic [1:0]  route1;
  logic [1:0]  route2;

  // Word index from byte address
  assign index = address[17:2];
  assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign route1 = cur.configActive[probe_latch_pkg::CFG_ROUTE1 +: 2];
  assign route2 = cur.configActive[probe_latch_pkg::CFG_ROUTE2 +: 2];

  // Input filters; polarity only from the restart-applied copy
  probe_input_filter #(.FILTER_W(10)) filter1 (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .invert     (cur.configActive[probe_latch_pkg::CFG_POL1]),
    .filterTime (cur.filter),
    .pin        (first_probe_input),
    .level      (lvl1)
  );
  probe_input_filter #(.FILTER_W(10)) filter2 (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .invert     (cur.configActive[probe_latch_pkg::CFG_POL2]),
    .filterTime (cur.filter),
    .pin        (second_probe_input),
    .level      (lvl2)
  );

  // Routing of the two inputs onto the channels; both may share one channel
  always_comb begin
    ext1 = ((route1 == probe_latch_pkg::ROUTE_CH1) & lvl1)
         | ((route2 == probe_latch_pkg::ROUTE_CH1) & lvl2);
    ext2 = ((route1 == probe_latch_pkg::ROUTE_CH2) & lvl1)
         | ((route2 == probe_latch_pkg::ROUTE_CH2) & lvl2);
  end

  probe_channel chan1 (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ctl        (cur.control[5:0]),
    .extLevel   (ext1),
    .indexLevel (indexPulse),
    .position   (position),
    .risePos    (pos1Rise),
    .fallPos    (pos1Fall),
    .status     (stat1)
  );
  probe_channel chan2 (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ctl        (cur.control[probe_latch_pkg::CH2_BASE +: 6]),
    .extLevel   (ext2),
    .indexLevel (indexPulse),
    .position   (position),
    .risePos    (pos2Rise),
    .fallPos    (pos2Fall),
    .status     (stat2)
  );

  // Bus slave: request accepted one cycle after it appears
  always_comb begin
    next_cur = cur;
    next_cur.ack = 1'b0;
    wval = 32'h0000_0000;
    if ((read || write) && !cur.ack) begin
      next_cur.ack = 1'b1;
      next_cur.rdata = 32'h0000_0000;
      if (read) begin
        unique case (index)
          probe_latch_pkg::IDX_P1_RISE: next_cur.rdata = pos1Rise;
          probe_latch_pkg::IDX_P1_FALL: next_cur.rdata = pos1Fall;
          probe_latch_pkg::IDX_P2_RISE: next_cur.rdata = pos2Rise;
          probe_latch_pkg::IDX_P2_FALL: next_cur.rdata = pos2Fall;
          probe_latch_pkg::IDX_CONTROL: next_cur.rdata = {16'h0000, cur.control};
          probe_latch_pkg::IDX_STATUS:  next_cur.rdata = {16'h0000, stat2, stat1};
          probe_latch_pkg::IDX_CONFIG:  next_cur.rdata = {26'h0000000, cur.configPending};
          probe_latch_pkg::IDX_FILTER:  next_cur.rdata = {22'h000000, cur.filter};
          default:                      next_cur.rdata = 32'h0000_0000;
        endcase
      end else begin
        unique case (index)
          probe_latch_pkg::IDX_CONTROL: begin
            wval = (writedata & wmask) | ({16'h0000, cur.control} & ~wmask);
            next_cur.control = wval[15:0];
          end
          probe_latch_pkg::IDX_CONFIG: begin
            wval = (writedata & wmask) | ({26'h0000000, cur.configPending} & ~wmask);
            // Out-of-range routing codes are refused per field
            if (wval[probe_latch_pkg::CFG_ROUTE1 +: 2] <= probe_latch_pkg::ROUTE_NONE) begin
              next_cur.configPending[probe_latch_pkg::CFG_ROUTE1 +: 2] = wval[probe_latch_pkg::CFG_ROUTE1 +: 2];
            end
            if (wval[probe_latch_pkg::CFG_ROUTE2 +: 2] <= probe_latch_pkg::ROUTE_NONE) begin
              next_cur.configPending[probe_latch_pkg::CFG_ROUTE2 +: 2] = wval[probe_latch_pkg::CFG_ROUTE2 +: 2];
            end
            next_cur.configPending[probe_latch_pkg::CFG_POL1] = wval[probe_latch_pkg::CFG_POL1];
            next_cur.configPending[probe_latch_pkg::CFG_POL2] = wval[probe_latch_pkg::CFG_POL2];
          end
          probe_latch_pkg::IDX_FILTER: begin
            wval = (writedata & wmask) | ({22'h000000, cur.filter} & ~wmask);
            // Immediate effect; values above the limit ignored
            if (wval[31:10] == 22'h000000 && wval[9:0] <= probe_latch_pkg::FILTER_MAX) begin
              next_cur.filter = wval[9:0];
            end
          end
          probe_latch_pkg::IDX_RESTART: begin
            // Soft restart applies staged routing and polarity
            if (byteenable[0] && writedata[0]) begin
              next_cur.configActive = cur.configPending;
            end
          end
          default: begin
            wval = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur.control       <= probe_latch_pkg::CONTROL_RESET;
      cur.filter        <= probe_latch_pkg::FILTER_RESET;
      cur.configPending <= probe_latch_pkg::CONFIG_RESET;
      cur.configActive  <= probe_latch_pkg::CONFIG_RESET;
      cur.rdata         <= 32'h0000_0000;
      cur.ack           <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // Waitrequest is low only in the ack cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= ~((read || write) && !cur.ack);
      readdata    <= next_cur.rdata;
    end
  end
endmodule

// >>> tb/probe_latch_monitor.sv
/*
  Port checker for the probe latch register slave.
  Assumes it is bound to the top module and sees its bus ports only.
*/
`timescale 1ns/1ns
module probe_latch_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Avalon-MM slave
  input wire logic [17:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest
);
  logic [15:0] idx;
  logic        unmapped;
  // Word index and holes in the map
  assign idx = address[17:2];
  assign unmapped = idx < probe_latch_pkg::IDX_CONTROL || idx > probe_latch_pkg::IDX_RESTART
                    || (idx > probe_latch_pkg::IDX_P2_FALL && idx < probe_latch_pkg::IDX_CONFIG);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Bits that must read zero at one index
  property rdMask(logic [15:0] i, logic [31:0] m);
    read && waitrequest && idx == i |=> !waitrequest && (readdata & m) == 32'h0;
  endproperty
  a_ack_next: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
  a_ack_single: assert property (!waitrequest |=> waitrequest) else $error("answer too long");
  a_no_spurious: assert property (!(read || write) |=> waitrequest) else $error("answer without request");
  a_read_hold: assert property (waitrequest && $past(waitrequest) |-> $stable(readdata)) else $error("readdata moved");
  a_unmapped_zero: assert property (read && waitrequest && unmapped |=> readdata == 32'h0) else $error("hole not zero");
  a_status_rsvd: assert property (rdMask(probe_latch_pkg::IDX_STATUS, 32'hFFFF3838)) else $error("status bits");
  a_ctrl_width: assert property (rdMask(probe_latch_pkg::IDX_CONTROL, 32'hFFFF0000)) else $error("control bits");
  a_filter_width: assert property (rdMask(probe_latch_pkg::IDX_FILTER, 32'hFFFFFC00)) else $error("filter bits");
  a_cfg_width: assert property (rdMask(probe_latch_pkg::IDX_CONFIG, 32'hFFFFFFC0)) else $error("config bits");
  // Main traffic seen
  c_read_res: cover property (read && idx == probe_latch_pkg::IDX_P1_RISE ##1 !waitrequest);
  c_write: cover property (write ##1 !waitrequest);
  c_hole: cover property (read && unmapped ##1 !waitrequest);
endmodule
bind touch_probe_position_latch probe_latch_monitor i_probe_latch_monitor (.mclk(mclk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest));

// >>> tb/probe_field_model.sv
/*
  Far-side model: two probe switches and position feedback.
  Assumes the bench asks for logical switch activity per input.
*/
`timescale 1ns/1ns
module probe_field_model (
  // Requests from the bench
  input  wire logic        act1,
  input  wire logic        act2,
  input  wire logic        inv1,
  input  wire logic        inv2,
  input  wire logic [31:0] posSet,
  input  wire logic        idxReq,
  // Pins towards the block
  output logic             pin1,
  output logic             pin2,
  output logic             indexPulse,
  output logic [31:0]      position
);
  // Uninverted inputs are active low, so an idle switch sits high
  assign pin1 = inv1 ? act1 : !act1;
  assign pin2 = inv2 ? act2 : !act2;
  // Encoder index level as the bench asks for it
  assign indexPulse = idxReq;
  assign position = posSet;
endmodule

// >>> tb/touch_probe_position_latch_bench.sv
/*
  Bench for the probe latch: defaults, latching, filter, routing.
  Assumes the field model and the bound monitor.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errTotal++; $display("unexpected %0t: got %h want %h", $time, a, b); end end
module touch_probe_position_latch_bench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [17:0] address = 18'h00000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] posSet = 32'h0;
  logic        act1 = 1'b0;
  logic        act2 = 1'b0;
  logic        inv1 = 1'b0;
  logic        idxReq = 1'b0;
  logic        pin1, pin2, idxPulse, waitrequest;
  logic [31:0] readdata, position, q;
  int          errTotal = 0;
  int          checked = 0;
  int          cycles = 0;

  touch_probe_position_latch i_touch_probe_position_latch (.mclk(mclk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .first_probe_input(pin1), .second_probe_input(pin2),
    .indexPulse(idxPulse), .position(position));
  probe_field_model i_probe_field_model (.act1(act1), .act2(act2), .inv1(inv1), .inv2(1'b0),
    .posSet(posSet), .idxReq(idxReq), .pin1(pin1), .pin2(pin2), .indexPulse(idxPulse), .position(position));

  // Clock of 50 ns
  always #25 mclk = !mclk;

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, the full run needs about 950 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      finishTest();
    end
  end

  // One transfer, held until waitrequest is sampled low
  // Only the hang guard ends a wait that never gets an answer
  task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
    @(posedge mclk);
    read <= !w;
    write <= w;
    address <= {i, 2'h0};
    writedata <= d;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    `CHK(q, e)
  endtask

  // Switch active for n cycles, position a on press and b on release
  task automatic pulse(input int ch, input int n, input logic [31:0] a, input logic [31:0] b);
    @(posedge mclk);
    posSet <= a;
    if (ch == 1) act1 <= 1'b1;
    else act2 <= 1'b1;
    repeat (n) @(posedge mclk);
    posSet <= b;
    act1 <= 1'b0;
    act2 <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  task automatic testDefaults();
    rd(probe_latch_pkg::IDX_CONTROL, 32'h0);
    rd(probe_latch_pkg::IDX_FILTER, 32'h0);
    rd(probe_latch_pkg::IDX_CONFIG, 32'h4);
    rd(probe_latch_pkg::IDX_STATUS, 32'h0);
    wr(probe_latch_pkg::IDX_P1_RISE, 32'hFFFFFFFF);
    rd(probe_latch_pkg::IDX_P1_RISE, 32'h0);
    rd(16'h1234, 32'h0);
    $display("test defaults done");
  endtask

  task automatic testChannel1();
    wr(probe_latch_pkg::IDX_CONTROL, 32'h33);
    pulse(1, 8, 32'hA5A50001, 32'hFFFFFF00);
    rd(probe_latch_pkg::IDX_P1_RISE, 32'hA5A50001);
    rd(probe_latch_pkg::IDX_P1_FALL, 32'hFFFFFF00);
    rd(probe_latch_pkg::IDX_STATUS, 32'h87);
    $display("test channel1 done");
  endtask

  task automatic testFilter();
    wr(probe_latch_pkg::IDX_FILTER, 32'h3E8);
    wr(probe_latch_pkg::IDX_FILTER, 32'h3E9);
    rd(probe_latch_pkg::IDX_FILTER, 32'h3E8);
    pulse(1, 100, 32'h22, 32'h23);
    rd(probe_latch_pkg::IDX_P1_RISE, 32'hA5A50001);
    pulse(1, 260, 32'h44, 32'h45);
    rd(probe_latch_pkg::IDX_P1_RISE, 32'h44);
    rd(probe_latch_pkg::IDX_P1_FALL, 32'h45);
    rd(probe_latch_pkg::IDX_STATUS, 32'h07);
    wr(probe_latch_pkg::IDX_FILTER, 32'h0);
    $display("test filter done");
  endtask

  task automatic testSingle();
    wr(probe_latch_pkg::IDX_CONTROL, 32'h3100);
    pulse(2, 8, 32'h0C0C0001, 32'h0C0C0002);
    pulse(2, 8, 32'h0D0D0001, 32'h0D0D0002);
    rd(probe_latch_pkg::IDX_P2_RISE, 32'h0C0C0001);
    rd(probe_latch_pkg::IDX_P2_FALL, 32'h0C0C0002);
    rd(probe_latch_pkg::IDX_STATUS, 32'h0706);
    $display("test single done");
  endtask

  task automatic testRouting();
    @(posedge mclk);
    inv1 <= 1'b1;
    wr(probe_latch_pkg::IDX_CONFIG, 32'h19);
    wr(probe_latch_pkg::IDX_RESTART, 32'h1);
    wr(probe_latch_pkg::IDX_CONTROL, 32'h3333);
    pulse(2, 8, 32'h0E0E0001, 32'h0E0E0002);
    rd(probe_latch_pkg::IDX_P1_RISE, 32'h44);
    rd(probe_latch_pkg::IDX_P2_RISE, 32'h0C0C0001);
    pulse(1, 8, 32'h0F0F0001, 32'h0F0F0002);
    rd(probe_latch_pkg::IDX_P2_RISE, 32'h0F0F0001);
    rd(probe_latch_pkg::IDX_P2_FALL, 32'h0F0F0002);
    rd(probe_latch_pkg::IDX_P1_RISE, 32'h44);
    $display("test routing done");
  endtask

  // Channel 1 on the index source, single mode, fresh enable
  task automatic testIndex();
    wr(probe_latch_pkg::IDX_CONTROL, 32'h3300);
    wr(probe_latch_pkg::IDX_CONTROL, 32'h3335);
    @(posedge mclk);
    posSet <= 32'h1D1D0001;
    idxReq <= 1'b1;
    repeat (4) @(posedge mclk);
    posSet <= 32'h1D1D0002;
    idxReq <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(probe_latch_pkg::IDX_P1_RISE, 32'h1D1D0001);
    rd(probe_latch_pkg::IDX_P1_FALL, 32'h1D1D0002);
    rd(probe_latch_pkg::IDX_STATUS, 32'h8707);
    $display("test index done");
  endtask

  // Reset for 16 cycles, then the scenarios in order
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    testDefaults();
    testChannel1();
    testFilter();
    testSingle();
    testRouting();
    testIndex();
    finishTest();
  end
endmodule
